// file: rtl/rlm_pkg.sv
// Constants for the rain and light measurement sequencer
package rlm_pkg;
	localparam int RES_W = 10;
	localparam int SUM_W = 14;
	localparam int NCH = 7;
	localparam logic [2:0] CH_RAIN = 3'h4;
	localparam logic [2:0] CH_TEMP = 3'h6;
	localparam logic [2:0] CH_LAST_SCAN = 3'h6;
	localparam logic [2:0] AVG_MAX = 3'h4;
	localparam logic [1:0] TEMP_AVG_MAX = 2'h3;
	localparam logic [9:0] RES_RST = 10'h000;
	localparam logic [9:0] TEMP_RST = 10'h3FF;
	localparam int RAIN_MOD_NS = 10000;
	localparam int LED_PULSE_NS = 2000;
	localparam int SCAN_INT_NS = 100000;
	localparam int CLK_NS = 10;
	localparam int RAIN_MOD_CYC = RAIN_MOD_NS / CLK_NS;
	localparam int LED_PULSE_CYC = LED_PULSE_NS / CLK_NS;
	localparam int SCAN_INT_CYC = SCAN_INT_NS / CLK_NS;
	localparam int FAST_SH = 3;
	localparam int SLOW_SH = 6;
endpackage : rlm_pkg

// file: rtl/rain_light_measure_seq.sv
// Rain loop and light ADC measurement sequencer
// Behaviour
// - Rain and ADC have independent enables
// - Blanking holds ADC start during LED pulse
// - Blanking skips rain slots during conversion
// - Overrunning conversion waits next interval boundary
// - Rain off: no LEDs, same scan timing
// - Loop bit picks next LED
// - Each LED has 16-step current trim
// - Bandpass filtered bit stream is rain value
// - Threshold padded with zero both ends
// - Comparator high when strictly greater
// - Mode bit routes comparator to pin
// - ADC covers light, temperature, reference
// - Scan converts selected channels in turn
// - Scan results kept per channel
// - Rain channel and rain run exclude
// - Manual command: channel, own exponent
// - Block average of two-power samples
// - Exponent chosen by measurement kind
// - Manual waits its slot, busy shown
// - Manual result in manual pair
// - Burst suspends scan, repeats back to back
// - Burst ends by bit or halt
// - Exponents clipped to 4, temp 3
// - Unsettled light samples flag invalid
// - Manual during manual gives error
`timescale 1ns/1ps
module rain_light_measure_seq #(
	parameter int RAIN_MOD_CYC = rlm_pkg::RAIN_MOD_CYC,
	parameter int SCAN_INT_CYC = rlm_pkg::SCAN_INT_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic rain_run_bit,
	input wire logic periodic_scan_mode,
	input wire logic blank_during_led,
	input wire logic [6:0] scan_channel_config,
	input wire logic [7:0] led_current_trim,
	input wire logic [7:0] rain_threshold_reg,
	input wire logic comparator_route,
	input wire logic [2:0] manual_avg_exp,
	input wire logic [2:0] scan_avg_exp,
	input wire logic [1:0] temp_avg_exp,
	input wire logic [7:0] settle_tolerance,
	input wire logic repeat_convert_bit,
	input wire logic measure_cmd,
	input wire logic [2:0] measure_chan,
	input wire logic halt_convert_cmd,
	input wire logic loop_bit,
	input wire logic adc_done,
	input wire logic [9:0] adc_data,
	output logic led_a_pulse_r,
	output logic led_b_pulse_r,
	output logic [3:0] led_a_trim_r,
	output logic [3:0] led_b_trim_r,
	output logic adc_start_r,
	output logic [2:0] adc_chan_r,
	output logic rain_active_r,
	output logic [9:0] rain_filtered_value_r,
	output logic comparator_out_pin_r,
	output logic busy_r,
	output logic not_executable_error_r,
	output logic [9:0] manual_result_r,
	output logic manual_invalid_r,
	output logic [6:0][9:0] scan_result_r,
	output logic [6:0] scan_invalid_r
);
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_BLANK = 2'h1,
		S_CONV = 2'h2
	} adc_state_e;

	localparam int SUM_W_L = rlm_pkg::SUM_W;

	adc_state_e state_r;
	logic [31:0] mod_cnt_r;
	logic [31:0] led_cnt_r;
	logic [31:0] int_cnt_r;
	logic mod_tick;
	logic int_tick;
	logic led_on;
	logic [12:0] fast_r;
	logic [12:0] slow_r;
	logic [12:0] fast_nxt;
	logic [12:0] slow_nxt;
	logic [12:0] diff;
	logic [9:0] thr_wide;
	logic pend_r;
	logic [2:0] pend_chan_r;
	logic burst_r;
	logic cur_manual_r;
	logic [2:0] cur_exp_r;
	logic [4:0] samp_r;
	logic [SUM_W_L-1:0] sum_r;
	logic [9:0] prev_r;
	logic inval_r;
	logic [2:0] last_scan_r;
	logic [2:0] scan_pick;
	logic scan_any;
	logic [6:0] scan_mask;
	logic [2:0] m_exp;
	logic [2:0] s_exp;
	logic [10:0] sdiff;
	logic unsettled;
	logic [4:0] n_need;
	logic [SUM_W_L-1:0] sum_nxt;
	logic [9:0] avg_nxt;
	logic conv_end;
	logic accept;

	// Rain modulation slot and LED pulse timing
	assign mod_tick = (mod_cnt_r == 32'(RAIN_MOD_CYC - 1));
	assign int_tick = (int_cnt_r == 32'(SCAN_INT_CYC - 1));
	assign led_on = led_a_pulse_r | led_b_pulse_r;

	// Free running timers keep scan timing regardless of rain state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mod_cnt_r <= 32'h0;
			int_cnt_r <= 32'h0;
		end else begin
			mod_cnt_r <= mod_tick ? 32'h0 : mod_cnt_r + 32'h1;
			int_cnt_r <= int_tick ? 32'h0 : int_cnt_r + 32'h1;
		end
	end

	// Rain run flag refused while rain channel in use
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rain_active_r <= 1'b0;
		end else if (!rain_run_bit) begin
			rain_active_r <= 1'b0;
		end else if (!rain_active_r) begin
			rain_active_r <= !(periodic_scan_mode && scan_channel_config[rlm_pkg::CH_RAIN])
				&& !(busy_r && pend_chan_r == rlm_pkg::CH_RAIN);
		end
	end

	// LED stimulus, side chosen by loop bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			led_a_pulse_r <= 1'b0;
			led_b_pulse_r <= 1'b0;
			led_cnt_r <= 32'h0;
		end else if (mod_tick && rain_active_r && rain_run_bit
				&& !(blank_during_led && state_r != S_IDLE)) begin
			led_a_pulse_r <= !loop_bit;
			led_b_pulse_r <= loop_bit;
			led_cnt_r <= 32'(rlm_pkg::LED_PULSE_CYC - 1);
		end else if (led_cnt_r != 32'h0 && rain_active_r) begin
			led_cnt_r <= led_cnt_r - 32'h1;
		end else begin
			led_a_pulse_r <= 1'b0;
			led_b_pulse_r <= 1'b0;
			led_cnt_r <= 32'h0;
		end
	end

	// Per LED sink current trim
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			led_a_trim_r <= 4'h0;
			led_b_trim_r <= 4'h0;
		end else begin
			led_a_trim_r <= led_current_trim[3:0];
			led_b_trim_r <= led_current_trim[7:4];
		end
	end

	// Bandpass: fast lowpass minus slow lowpass of bit stream
	always_comb begin
		fast_nxt = fast_r + 13'($signed((loop_bit ? 13'h0FFF : 13'h0000) - fast_r)
			>>> rlm_pkg::FAST_SH);
		slow_nxt = slow_r + 13'($signed(fast_r - slow_r) >>> rlm_pkg::SLOW_SH);
		diff = (fast_r > slow_r) ? fast_r - slow_r : 13'h0000;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fast_r <= 13'h0000;
			slow_r <= 13'h0000;
			rain_filtered_value_r <= rlm_pkg::RES_RST;
		end else if (mod_tick && rain_active_r) begin
			fast_r <= fast_nxt;
			slow_r <= slow_nxt;
			rain_filtered_value_r <= diff[11:2];
		end
	end

	// Threshold compare routed to pin
	assign thr_wide = {1'b0, rain_threshold_reg, 1'b0};
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			comparator_out_pin_r <= 1'b0;
		end else begin
			comparator_out_pin_r <= comparator_route
				&& (rain_filtered_value_r > thr_wide);
		end
	end

	// Next selected scan channel after the last one
	always_comb begin
		scan_mask = scan_channel_config;
		if (rain_active_r) begin
			scan_mask[rlm_pkg::CH_RAIN] = 1'b0;
		end
		scan_pick = 3'h0;
		scan_any = 1'b0;
		for (int i = rlm_pkg::NCH - 1; i >= 0; i--) begin
			if (scan_mask[i] && 3'(i) > last_scan_r) begin
				scan_pick = 3'(i);
				scan_any = 1'b1;
			end
		end
		if (!scan_any) begin
			for (int i = rlm_pkg::NCH - 1; i >= 0; i--) begin
				if (scan_mask[i]) begin
					scan_pick = 3'(i);
					scan_any = 1'b1;
				end
			end
		end
	end

	// Exponent clipping and sample bookkeeping
	assign m_exp = (manual_avg_exp > rlm_pkg::AVG_MAX) ? rlm_pkg::AVG_MAX : manual_avg_exp;
	assign s_exp = (scan_avg_exp > rlm_pkg::AVG_MAX) ? rlm_pkg::AVG_MAX : scan_avg_exp;
	assign n_need = 5'h01 << cur_exp_r;
	assign sum_nxt = sum_r + SUM_W_L'(adc_data);
	assign avg_nxt = 10'(sum_nxt >> cur_exp_r);
	assign sdiff = (adc_data > prev_r) ? 11'(adc_data - prev_r) : 11'(prev_r - adc_data);
	assign unsettled = (samp_r != 5'h00) && (adc_chan_r < rlm_pkg::CH_RAIN + 3'h1)
		&& (sdiff >= 11'(settle_tolerance));
	assign conv_end = (state_r == S_CONV) && adc_done && (samp_r + 5'h01 == n_need);
	assign accept = measure_cmd && !busy_r
		&& !(measure_chan == rlm_pkg::CH_RAIN && rain_active_r);

	// Manual command intake, busy and error
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 1'b0;
			pend_chan_r <= 3'h0;
			busy_r <= 1'b0;
			not_executable_error_r <= 1'b0;
			burst_r <= 1'b0;
		end else begin
			not_executable_error_r <= measure_cmd && !accept;
			if (accept) begin
				pend_r <= 1'b1;
				pend_chan_r <= measure_chan;
				busy_r <= 1'b1;
				burst_r <= repeat_convert_bit;
			end else begin
				if (burst_r && (!repeat_convert_bit || halt_convert_cmd)) begin
					burst_r <= 1'b0;
					// Drop the retrigger queued behind a running repeat
					if (state_r != S_IDLE) begin
						pend_r <= 1'b0;
					end
				end
				if (state_r == S_IDLE && pend_r && (int_tick || burst_r)) begin
					pend_r <= burst_r && repeat_convert_bit && !halt_convert_cmd;
				end
				if (conv_end && cur_manual_r && !(burst_r && repeat_convert_bit
						&& !halt_convert_cmd)) begin
					busy_r <= 1'b0;
				end
			end
		end
	end

	// Conversion sequencer with averaging and blanking
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			adc_start_r <= 1'b0;
			adc_chan_r <= 3'h0;
			cur_manual_r <= 1'b0;
			cur_exp_r <= 3'h0;
			samp_r <= 5'h00;
			sum_r <= '0;
			prev_r <= 10'h000;
			inval_r <= 1'b0;
			last_scan_r <= rlm_pkg::CH_LAST_SCAN;
		end else begin
			adc_start_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					samp_r <= 5'h00;
					sum_r <= '0;
					inval_r <= 1'b0;
					if (pend_r && (int_tick || burst_r)) begin
						adc_chan_r <= pend_chan_r;
						cur_manual_r <= 1'b1;
						cur_exp_r <= (pend_chan_r == rlm_pkg::CH_TEMP)
							? {1'b0, temp_avg_exp} : m_exp;
						state_r <= S_BLANK;
					end else if (int_tick && periodic_scan_mode && scan_any
							&& !burst_r) begin
						adc_chan_r <= scan_pick;
						last_scan_r <= scan_pick;
						cur_manual_r <= 1'b0;
						cur_exp_r <= (scan_pick == rlm_pkg::CH_TEMP)
							? {1'b0, temp_avg_exp} : s_exp;
						state_r <= S_BLANK;
					end
				end
				S_BLANK: begin
					if (!(blank_during_led && led_on)) begin
						adc_start_r <= 1'b1;
						state_r <= S_CONV;
					end
				end
				S_CONV: begin
					if (adc_done) begin
						prev_r <= adc_data;
						inval_r <= inval_r | unsettled;
						if (conv_end) begin
							state_r <= S_IDLE;
						end else begin
							samp_r <= samp_r + 5'h01;
							sum_r <= sum_nxt;
							state_r <= S_BLANK;
						end
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Manual result pair
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			manual_result_r <= rlm_pkg::RES_RST;
			manual_invalid_r <= 1'b0;
		end else if (conv_end && cur_manual_r) begin
			manual_result_r <= avg_nxt;
			manual_invalid_r <= inval_r | unsettled;
		end
	end

	// Per channel scan result registers
	for (genvar g = 0; g < rlm_pkg::NCH; g++) begin : g_res
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				scan_result_r[g] <= (g == rlm_pkg::CH_TEMP) ? rlm_pkg::TEMP_RST
					: rlm_pkg::RES_RST;
				scan_invalid_r[g] <= 1'b0;
			end else if (conv_end && !cur_manual_r && adc_chan_r == 3'(g)) begin
				scan_result_r[g] <= avg_nxt;
				scan_invalid_r[g] <= inval_r | unsettled;
			end
		end
	end
endmodule : rain_light_measure_seq

// file: tb/rlm_props.sv
// Port checker for the measurement sequencer
`timescale 1ns/1ps
module rlm_props #(
	parameter int RAIN_MOD_CYC = 20,
	parameter int SCAN_INT_CYC = 200
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic blank_during_led,
	input wire logic [7:0] led_current_trim,
	input wire logic [7:0] rain_threshold_reg,
	input wire logic comparator_route,
	input wire logic measure_cmd,
	input wire logic [2:0] measure_chan,
	input wire logic led_a_pulse_r,
	input wire logic led_b_pulse_r,
	input wire logic [3:0] led_a_trim_r,
	input wire logic [3:0] led_b_trim_r,
	input wire logic adc_start_r,
	input wire logic rain_active_r,
	input wire logic [9:0] rain_filtered_value_r,
	input wire logic comparator_out_pin_r,
	input wire logic busy_r,
	input wire logic not_executable_error_r
);
	// Either LED lit
	wire led_on = led_a_pulse_r | led_b_pulse_r;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// Relations at the ports
	a_led_one_only: assert property (!(led_a_pulse_r && led_b_pulse_r))
		else $error("both LEDs on");
	a_led_needs_rain: assert property ($rose(led_on) |-> rain_active_r)
		else $error("LED pulse without rain loop");
	a_trim_follows: assert property ($past(rstn) && $stable(led_current_trim)
		|-> {led_b_trim_r, led_a_trim_r} == led_current_trim)
		else $error("LED trim mismatch");
	a_cmp_strict: assert property ((comparator_route && $stable(rain_filtered_value_r)
		&& $stable(rain_threshold_reg))[*3] |-> comparator_out_pin_r
		== (rain_filtered_value_r > {1'b0, rain_threshold_reg, 1'b0}))
		else $error("comparator pin wrong");
	a_cmd_sets_busy: assert property (measure_cmd && !busy_r && measure_chan != rlm_pkg::CH_RAIN
		|=> busy_r)
		else $error("busy not raised");
	a_busy_refused: assert property (measure_cmd && busy_r |=> not_executable_error_r)
		else $error("no error on busy command");
	a_rain_chan_refused: assert property (measure_cmd && !busy_r && rain_active_r
		&& measure_chan == rlm_pkg::CH_RAIN |=> not_executable_error_r && !busy_r)
		else $error("rain channel accepted");
	a_blank_hold: assert property (blank_during_led && $past(blank_during_led) && led_on
		&& $past(led_on) |-> !adc_start_r)
		else $error("conversion during LED");
	a_start_bound: assert property ($rose(busy_r) |-> ##[1:1000] adc_start_r)
		else $error("conversion never started");
	c_done: cover property ($fell(busy_r));
	c_err: cover property (not_executable_error_r);
	c_rain_adc: cover property (adc_start_r && rain_active_r);
endmodule : rlm_props

bind rain_light_measure_seq rlm_props #(
	.RAIN_MOD_CYC(RAIN_MOD_CYC),
	.SCAN_INT_CYC(SCAN_INT_CYC)
) props_u (
	.clk_sys, .rstn, .blank_during_led, .led_current_trim, .rain_threshold_reg,
	.comparator_route, .measure_cmd, .measure_chan, .led_a_pulse_r, .led_b_pulse_r,
	.led_a_trim_r, .led_b_trim_r, .adc_start_r, .rain_active_r, .rain_filtered_value_r,
	.comparator_out_pin_r, .busy_r, .not_executable_error_r
);

// file: tb/rlm_adc_model.sv
// Behavioural ADC answering each start after a short or long delay
`timescale 1ns/1ps
module rlm_adc_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic adc_start_r,
	input wire logic [9:0] base_val,
	output logic adc_done,
	output logic [9:0] adc_data
);
	int wait_r;
	logic hi_r;
	logic slow_r;
	logic [9:0] val;
	// Samples alternate by two so any even block averages to base plus one
	assign val = hi_r ? base_val + 10'h002 : base_val;
	// Data only valid with done, scrambled otherwise
	assign adc_data = adc_done ? val : ~val;
	// One answer per start, delay alternating prompt and slow
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_r <= 0;
			hi_r <= 1'b0;
			slow_r <= 1'b0;
			adc_done <= 1'b0;
		end else if (adc_start_r) begin
			wait_r <= slow_r ? 12 : 3;
			slow_r <= ~slow_r;
			adc_done <= 1'b0;
		end else begin
			wait_r <= (wait_r > 0) ? wait_r - 1 : 0;
			adc_done <= (wait_r == 1);
			hi_r <= hi_r ^ (wait_r == 1);
		end
	end
endmodule : rlm_adc_model

// file: tb/rain_light_measure_seq_test.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module rain_light_measure_seq_test;
	logic clk_sys, rstn, rain_run_bit, periodic_scan_mode, blank_during_led, comparator_route;
	logic repeat_convert_bit, measure_cmd, halt_convert_cmd, loop_bit, adc_done, busy_d;
	logic led_a_pulse_r, led_b_pulse_r, adc_start_r, rain_active_r, comparator_out_pin_r;
	logic busy_r, not_executable_error_r, manual_invalid_r;
	logic [7:0] led_current_trim, rain_threshold_reg, settle_tolerance;
	logic [6:0] scan_channel_config, scan_invalid_r;
	logic [3:0] led_a_trim_r, led_b_trim_r;
	logic [2:0] manual_avg_exp, scan_avg_exp, measure_chan, adc_chan_r;
	logic [1:0] temp_avg_exp;
	logic [9:0] adc_data, base_val, rain_filtered_value_r, manual_result_r;
	logic [6:0][9:0] scan_result_r;
	logic [10:0] notes[$];
	int failures, samples_checked, cyc;
	integer seed;

	rain_light_measure_seq #(.RAIN_MOD_CYC(500), .SCAN_INT_CYC(200)) dut_u (
		.clk_sys, .rstn, .rain_run_bit, .periodic_scan_mode, .blank_during_led,
		.scan_channel_config, .led_current_trim, .rain_threshold_reg, .comparator_route,
		.manual_avg_exp, .scan_avg_exp, .temp_avg_exp, .settle_tolerance, .repeat_convert_bit,
		.measure_cmd, .measure_chan, .halt_convert_cmd, .loop_bit, .adc_done, .adc_data,
		.led_a_pulse_r, .led_b_pulse_r, .led_a_trim_r, .led_b_trim_r, .adc_start_r, .adc_chan_r,
		.rain_active_r, .rain_filtered_value_r, .comparator_out_pin_r, .busy_r,
		.not_executable_error_r, .manual_result_r, .manual_invalid_r, .scan_result_r,
		.scan_invalid_r
	);
	rlm_adc_model adc_u (.clk_sys, .rstn, .adc_start_r, .base_val, .adc_done, .adc_data);

	// Compare and count
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] want);
		samples_checked++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	// Counts, verdict and end of run
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// One manual command; valid ones leave a note of the result
	task automatic measure(input logic [2:0] ch, input logic [2:0] ex, input logic bad);
		@(negedge clk_sys);
		measure_chan = ch;
		manual_avg_exp = ex;
		measure_cmd = 1'b1;
		if (!bad) notes.push_back({ch <= 3'h4 && settle_tolerance < 8'h03, base_val + 10'h001});
		@(negedge clk_sys);
		measure_cmd = 1'b0;
		if (bad) check("refusal", not_executable_error_r, 1'b1);
		else check("busy", busy_r, 1'b1);
	endtask : measure

	// Bounded wait for the manual conversion to end
	task automatic wait_idle;
		for (int i = 0; i < 4000 && busy_r !== 1'b0; i++) @(negedge clk_sys);
		@(negedge clk_sys);
	endtask : wait_idle

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Loop bit, hang guard and result monitor
	always @(negedge clk_sys) begin
		loop_bit <= 1'($random(seed));
		cyc <= cyc + 1;
		busy_d <= busy_r;
		if (cyc > 60000) begin
			failures++;
			wrap_up();
		end else if (busy_d === 1'b1 && busy_r === 1'b0 && notes.size() > 0) begin
			check("manual", {manual_invalid_r, manual_result_r}, notes.pop_front());
		end
	end

	// Reset, then the scenarios in turn
	initial begin
		seed = 32'hA0CE9A39;
		{rstn, rain_run_bit, periodic_scan_mode, blank_during_led, comparator_route} = 5'h00;
		{repeat_convert_bit, measure_cmd, halt_convert_cmd, loop_bit, busy_d} = 5'h00;
		{measure_chan, manual_avg_exp, scan_avg_exp, temp_avg_exp} = 11'h009;
		scan_channel_config = 7'h41;
		led_current_trim = 8'($random(seed));
		rain_threshold_reg = 8'($random(seed));
		settle_tolerance = 8'h03;
		base_val = 10'h100;
		{cyc, failures, samples_checked} = 0;
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		for (int i = 0; i < 12; i++) begin
			base_val = 10'({$random(seed)} % 1000);
			settle_tolerance = 8'(2 + i % 2);
			measure(3'(i), 3'({$random(seed)} % 7 + 1), 1'b0);
			measure(3'h2, 3'h1, 1'b1);
			wait_idle();
		end
		check("rain idle", rain_filtered_value_r, 11'h000);
		$display("manual conversions done");
		rain_run_bit = 1'b1;
		blank_during_led = 1'b1;
		comparator_route = 1'b1;
		repeat (1500) @(negedge clk_sys);
		check("rain run", rain_active_r, 1'b1);
		led_current_trim = 8'($random(seed));
		measure(rlm_pkg::CH_RAIN, 3'h1, 1'b1);
		measure(3'h0, 3'h2, 1'b0);
		wait_idle();
		$display("rain with blanking done");
		rain_run_bit = 1'b0;
		blank_during_led = 1'b0;
		repeat_convert_bit = 1'b1;
		measure(3'h1, 3'h1, 1'b0);
		repeat (400) @(negedge clk_sys);
		check("burst", {busy_r, manual_result_r}, {1'b1, base_val + 10'h001});
		check("burst chan", adc_chan_r, 11'h001);
		halt_convert_cmd = 1'b1;
		@(negedge clk_sys);
		halt_convert_cmd = 1'b0;
		repeat_convert_bit = 1'b0;
		wait_idle();
		check("comparator", comparator_out_pin_r,
			rain_filtered_value_r > {1'b0, rain_threshold_reg, 1'b0});
		$display("burst done");
		periodic_scan_mode = 1'b1;
		repeat (2000) @(negedge clk_sys);
		check("scan light", scan_result_r[0], base_val + 10'h001);
		check("scan temp", scan_result_r[6], base_val + 10'h001);
		check("scan valid", scan_invalid_r[0], 1'b0);
		scan_channel_config = 7'h51;
		rain_run_bit = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("rain refused", rain_active_r, 1'b0);
		rain_run_bit = 1'b0;
		scan_channel_config = 7'h41;
		measure(3'h7, 3'h5, 1'b0);
		wait_idle();
		check("notes left", 11'(notes.size()), 11'h000);
		$display("scan done");
		wrap_up();
	end
endmodule : rain_light_measure_seq_test
